// *** rtcc_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
// Device end: slave front end; data bytes leave via a skid buffer
module rtcc_slave (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	// Bus
	rtcc_bus_if.slave BUS,
	// Power and pin control
	input wire logic ON_BACKUP_IN,
	input wire logic MFP_LEVEL_IN,
	output logic MULTIFUNCTION_OUTPUT_PIN_OE_OUT,
	// Received bytes
	output logic RX_VALID_OUT,
	input wire logic RX_READY_IN,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_FIRST_OUT,
	// Bytes to send
	input wire logic [7:0] TX_DATA_IN,
	output logic TX_TAKE_OUT,
	// Status
	output logic BUSY_OUT,
	output logic READ_NOT_WRITE_BIT_OUT
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Transfer phase: idle, control, then write or read
	typedef enum logic [1:0] {RTCC_IDLE = 2'b00, RTCC_CTRL = 2'b01, RTCC_WR = 2'b11,
		RTCC_RD = 2'b10} rtcc_state_t;
	rtcc_state_t state;
	// Line history and per-transfer flags
	logic scl_d, sda_d, first, nack, ack_ok;
	// Bit slot: 0 to 7 data, 8 the acknowledge
	logic [3:0] bitn;
	// Receive and transmit shifters
	logic [7:0] sh, txs;
	// Write side of the receive buffer
	logic fin_valid, fin_ready;
	logic [7:0] fin_data;
	// Read side of the receive buffer
	logic out_v;
	logic out_first;
	logic [7:0] out_d;
	// Bus conditions, seen against last cycle's lines
	// The clock must be high on both samples, so a data move next to a
	// clock edge is never taken for Start or Stop
	wire scl_rise = BUS.scl && !scl_d;
	wire scl_fall = !BUS.scl && scl_d;
	wire start_c = BUS.scl && scl_d && sda_d && !BUS.sda;
	wire stop_c = BUS.scl && scl_d && !sda_d && BUS.sda;
	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	// Control byte matched with the read direction bit set
	function automatic logic read_grant(input rtcc_state_t st, input logic ok,
		input logic [7:0] ctl);
		return (st == RTCC_CTRL) && ok && ctl[0];
	endfunction : read_grant
	// ----------------------------------------
	// Bus sampling and framing
	// ----------------------------------------
	// Edge history of both lines
	// Idle level after reset, so no false edge follows reset
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= BUS.scl;
			sda_d <= BUS.sda;
		end
	end
	// Transfer state; backup power forces idle
	// Stop wins over Start; backup power drops a transfer at once
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN || ON_BACKUP_IN) begin
			state <= RTCC_IDLE;
			bitn <= 4'h0_000;
			sh <= 8'h0_000;
			first <= 1'b0;
			nack <= 1'b0;
			READ_NOT_WRITE_BIT_OUT <= 1'b0;
		end else if (stop_c) begin
			state <= RTCC_IDLE;
		end else if (start_c) begin
			state <= RTCC_CTRL;
			// The clock fall that ends Start wraps this to bit zero
			bitn <= '1;
			first <= 1'b1;
			nack <= 1'b0;
		end else if (state != RTCC_IDLE && scl_rise) begin
			if (bitn <= rtcc_pkg::LAST_BIT) begin
				sh <= {sh[6:0], BUS.sda};
			end else if (state == RTCC_RD) begin
				nack <= BUS.sda;
			end
		end else if (state != RTCC_IDLE && scl_fall) begin
			if (bitn == rtcc_pkg::ACK_BIT) begin
				bitn <= 4'h0_000;
				if (state == RTCC_CTRL) begin
					state <= !ack_ok ? RTCC_IDLE : (sh[0] ? RTCC_RD : RTCC_WR);
					READ_NOT_WRITE_BIT_OUT <= sh[0];
				end else if (state == RTCC_WR) begin
					first <= 1'b0;
				end else if (nack) begin
					state <= RTCC_IDLE;
				end
			end else begin
				bitn <= bitn + 4'h0_001;
			end
		end
	end
	// Acknowledge decision, made at the eighth bit
	// A refused byte is left unacked; the master sees a high ninth bit
	// Limitation: no clock stretching, so a full buffer costs a refused byte
	always_comb begin
		if (state == RTCC_CTRL) begin
			ack_ok = rtcc_pkg::rtcc_addr_match(sh);
		end else if (state == RTCC_WR) begin
			// Full buffer or bad pointer gets no ack
			ack_ok = fin_ready && (!first || rtcc_pkg::rtcc_reg_valid(sh));
		end else begin
			ack_ok = 1'b0;
		end
	end
	assign fin_valid = (state == RTCC_WR) && scl_fall && (bitn == rtcc_pkg::LAST_BIT) && ack_ok;
	assign fin_data = sh;
	// ----------------------------------------
	// Output driving
	// ----------------------------------------
	// Data line pull-down, set on falling clock, released at Start or Stop
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN || ON_BACKUP_IN) begin
			BUS.sda_s_oe <= 1'b0;
			txs <= 8'h0_000;
			TX_TAKE_OUT <= 1'b0;
		end else begin
			TX_TAKE_OUT <= 1'b0;
			// Let go at any Start or Stop
			if (start_c || stop_c) begin
				BUS.sda_s_oe <= 1'b0;
			end else if (scl_fall) begin
				// Ack slot follows the eighth data bit
				if (bitn == rtcc_pkg::LAST_BIT && state != RTCC_RD) begin
					BUS.sda_s_oe <= ack_ok;
					if (read_grant(state, ack_ok, sh)) begin
						txs <= TX_DATA_IN;
						TX_TAKE_OUT <= 1'b1;
					end
				end else if (bitn == rtcc_pkg::ACK_BIT && read_grant(state, ack_ok, sh)) begin
					BUS.sda_s_oe <= ~txs[7];
					txs <= {txs[6:0], 1'b0};
				end else if (bitn == rtcc_pkg::ACK_BIT && state == RTCC_RD && !nack) begin
					BUS.sda_s_oe <= ~TX_DATA_IN[7];
					txs <= {TX_DATA_IN[6:0], 1'b0};
					TX_TAKE_OUT <= 1'b1;
				end else if (state == RTCC_RD && bitn < rtcc_pkg::LAST_BIT) begin
					BUS.sda_s_oe <= ~txs[7]; // only pulls low
					txs <= {txs[6:0], 1'b0};
				end else begin
					BUS.sda_s_oe <= 1'b0; // Release for ack or after nack
				end
			end
		end
	end
	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	// Received data buffer; the flag marks the register address byte
	rtcc_fifo2 #(.WIDTH(9)) u_rtcc_fifo2 (
		.clk_in(CORE_CLK_IN),
		.resetn_in(RESETN_IN),
		.in_valid_in(fin_valid),
		.in_ready_out(fin_ready),
		.in_data_in({first, fin_data}),
		.out_valid_out(out_v),
		.out_ready_in(RX_READY_IN && !RX_VALID_OUT),
		.out_data_out({out_first, out_d})
	);
	// ----------------------------------------
	// Status and pin
	// ----------------------------------------
	// Registered outputs
	// One-cycle valid, then a gap cycle, so a held ready never takes
	// one word twice
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN) begin
			RX_VALID_OUT <= 1'b0;
			RX_DATA_OUT <= 8'h0_000;
			RX_FIRST_OUT <= 1'b0;
			BUSY_OUT <= 1'b0;
			MULTIFUNCTION_OUTPUT_PIN_OE_OUT <= 1'b0;
		end else begin
			BUSY_OUT <= (state != RTCC_IDLE);
			// Pin pulled low while the level asks for low; open drain only
			MULTIFUNCTION_OUTPUT_PIN_OE_OUT <= ~MFP_LEVEL_IN;
			if (RX_VALID_OUT) begin
				RX_VALID_OUT <= 1'b0;
			end else if (out_v && RX_READY_IN) begin
				RX_VALID_OUT <= 1'b1;
				RX_FIRST_OUT <= out_first;
				RX_DATA_OUT <= out_d;
			end
		end
	end
endmodule : rtcc_slave
`default_nettype wire

// *** rtcc_pkg.sv ***
// Overview of operation
// - Device data pin only pulls low or releases
// - Data changes only while serial clock low
// - Master alone makes Start, Stop, direction
// - Transfers begin only on an idle bus
// - Data fall with clock high is Start
// - Data rise with clock high is Stop
// - One bit per clock pulse, stable high
// - Master chooses byte count; device accepts any
// - Device acknowledges every received byte when addressed; here a full buffer or bad register pointer gets no ack
// - Master adds ninth clock for acknowledge
// - Master does not acknowledge last read byte
// - On master not-acknowledge, device releases data line
// - Backup supply disables the serial interface
// - Control byte upper nibble must be 1101
// - Three chip-select bits must all be one
// - Last control bit: one read, zero write
// - Matching address acknowledged, then read or write
// - Multifunction pin is open-drain output only
// - Out-of-range register address is not acknowledged
// - Registers 0x00-0x1F, memory 0x20-0x5F, shared space
package rtcc_pkg;
	// ----------------------------------------
	// Addressing
	// ----------------------------------------
	localparam logic [3:0] CONTROL_CODE = 4'h0_00D;
	localparam logic [2:0] CHIP_SELECT = 3'h0_007;
	localparam logic [7:0] RTC_FIRST = 8'h0_000;
	localparam logic [7:0] RTC_LAST = 8'h0_01F;
	localparam logic [7:0] SRAM_FIRST = 8'h0_020;
	localparam logic [7:0] SRAM_LAST = 8'h0_05F;
	// ----------------------------------------
	// Framing and timing
	// ----------------------------------------
	localparam int BYTE_BITS = 8;
	localparam int CLK_HZ = 50_000_000;
	localparam int SCL_HZ = 400_000;
	localparam int HALF_CYCLES = CLK_HZ / (2 * SCL_HZ);
	localparam logic [3:0] LAST_BIT = 4'h0_007;
	localparam logic [3:0] ACK_BIT = 4'h0_008;
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Seven-bit slave address check
	function automatic logic rtcc_addr_match(input logic [7:0] ctl);
		return (ctl[7:4] == CONTROL_CODE) && (ctl[3:1] == CHIP_SELECT);
	endfunction : rtcc_addr_match
	// Implemented memory window
	function automatic logic rtcc_reg_valid(input logic [7:0] a);
		return (a <= SRAM_LAST);
	endfunction : rtcc_reg_valid
endpackage : rtcc_pkg

// *** rtcc_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Two-wire bus; data is wired-AND of both ends' pull-downs, clock pulled by master only
interface rtcc_bus_if;
	logic scl_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport master (output scl_oe, output sda_m_oe, input scl, input sda);
	modport slave (output sda_s_oe, input scl, input sda);
endinterface : rtcc_bus_if
`default_nettype wire

// *** rtcc_fifo2.sv ***
`timescale 1ns/100ps
`default_nettype none
// Two-entry skid buffer
module rtcc_fifo2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;
	assign push = in_valid_in && (count != 2'd2);
	assign pop = out_valid_out && out_ready_in;
	assign in_ready_out = (count != 2'd2);
	assign out_valid_out = (count != 2'd0);
	assign out_data_out = mem[rd_ptr];
	// Storage and pointers
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_in;
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : rtcc_fifo2
`default_nettype wire

// *** rtcc_master.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far end: simple two-wire master, one byte per command
module rtcc_master (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	// Bus
	rtcc_bus_if.master BUS,
	// Commands
	input wire logic CMD_VALID_IN,
	input wire logic CMD_START_IN,
	input wire logic CMD_STOP_IN,
	input wire logic CMD_READ_IN,
	input wire logic CMD_LAST_IN,
	input wire logic [7:0] CMD_DATA_IN,
	output logic CMD_READY_OUT,
	output logic DONE_OUT,
	output logic ACK_OUT,
	output logic [7:0] RD_DATA_OUT
);
	typedef enum logic [2:0] {RTCM_IDLE = 3'b000, RTCM_START = 3'b001, RTCM_BIT = 3'b011,
		RTCM_STOP = 3'b010, RTCM_END = 3'b110} rtcm_state_t;
	rtcm_state_t state;
	logic [7:0] div;
	logic tick;
	logic [1:0] ph;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic rd, last, stp;
	// Quarter-bit enable from divider
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN || div == 8'(rtcc_pkg::HALF_CYCLES / 2 - 1)) begin
			div <= 8'h0_000;
		end else begin
			div <= div + 8'h0_001;
		end
	end
	assign tick = (div == 8'h0_000);
	// Master sequencer: optional Start, nine clocks, optional Stop
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN) begin
			state <= RTCM_IDLE;
			BUS.scl_oe <= 1'b0;
			BUS.sda_m_oe <= 1'b0;
			CMD_READY_OUT <= 1'b0;
			DONE_OUT <= 1'b0;
			ACK_OUT <= 1'b0;
			RD_DATA_OUT <= 8'h0_000;
			ph <= 2'd0;
			bitn <= 4'h0_000;
			sh <= 8'h0_000;
			rd <= 1'b0;
			last <= 1'b0;
			stp <= 1'b0;
		end else begin
			DONE_OUT <= 1'b0;
			CMD_READY_OUT <= (state == RTCM_IDLE) && !CMD_VALID_IN;
			case (state)
			RTCM_IDLE: begin
				if (CMD_VALID_IN && CMD_READY_OUT) begin
					CMD_READY_OUT <= 1'b0;
					sh <= CMD_READ_IN ? 8'h0_0FF : CMD_DATA_IN;
					rd <= CMD_READ_IN;
					last <= CMD_LAST_IN;
					stp <= CMD_STOP_IN;
					ph <= 2'd0;
					bitn <= 4'h0_000;
					state <= CMD_START_IN ? RTCM_START : RTCM_BIT;
				end
			end
			RTCM_START: if (tick) begin
				ph <= ph + 2'd1;
				if (ph == 2'd0) begin
					BUS.sda_m_oe <= 1'b0;
				end else if (ph == 2'd1) begin
					BUS.scl_oe <= 1'b0;
				end else if (ph == 2'd2 && BUS.scl && BUS.sda) begin
					BUS.sda_m_oe <= 1'b1;
				end else if (ph == 2'd3) begin
					BUS.scl_oe <= 1'b1;
					state <= RTCM_BIT;
				end
			end
			RTCM_BIT: if (tick) begin
				ph <= ph + 2'd1;
				if (ph == 2'd0) begin // Change data while low
					if (bitn <= rtcc_pkg::LAST_BIT) begin
						BUS.sda_m_oe <= ~sh[7];
					end else begin
						BUS.sda_m_oe <= rd && !last;
					end
				end else if (ph == 2'd1) begin
					BUS.scl_oe <= 1'b0;
				end else if (ph == 2'd2) begin
					if (bitn <= rtcc_pkg::LAST_BIT) begin
						sh <= {sh[6:0], BUS.sda};
					end else begin
						ACK_OUT <= !BUS.sda;
					end
				end else begin
					BUS.scl_oe <= 1'b1;
					if (bitn == rtcc_pkg::ACK_BIT) begin
						RD_DATA_OUT <= sh;
						state <= stp ? RTCM_STOP : RTCM_END;
						ph <= 2'd0;
					end else begin
						bitn <= bitn + 4'h0_001;
					end
				end
			end
			RTCM_STOP: if (tick) begin
				ph <= ph + 2'd1;
				if (ph == 2'd0) begin
					BUS.sda_m_oe <= 1'b1;
				end else if (ph == 2'd1) begin
					BUS.scl_oe <= 1'b0;
				end else if (ph == 2'd2) begin
					BUS.sda_m_oe <= 1'b0;
					state <= RTCM_END;
				end
			end
			RTCM_END: begin
				if (!stp) begin
					BUS.sda_m_oe <= 1'b0;
				end
				DONE_OUT <= 1'b1;
				state <= RTCM_IDLE;
			end
			default: state <= RTCM_IDLE;
			endcase
		end
	end
endmodule : rtcc_master
`default_nettype wire

// *** rtcc_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtcc_assertions (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	// Bus lines
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// ----------------------------------------
	// Framing helpers
	// ----------------------------------------
	logic scl_q;
	logic sda_q;
	logic [3:0] cnt;
	wire logic start = sda_q && !sda && scl;
	wire logic stop = !sda_q && sda && scl;
	// Line history for edge spotting
	always_ff @(posedge CORE_CLK_IN) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// Clock rises since Start; nine closes a byte with its ack slot
	// A Stop rides on the first rise after the ack slot
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN || start) begin
			cnt <= 4'h0;
		end else if (scl && !scl_q) begin
			cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_SLAVE_MOVES_LOW: assert property (!$stable(sda_s_oe) |-> !scl)
		else $error("slave data moved with clock high");
	AST_CLOCK_HIGH_HOLD: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high too short");
	AST_START_SHAPE: assert property (start |-> (scl && !sda_s_oe) [*8])
		else $error("start not held or slave driving");
	AST_START_BY_MASTER: assert property (start |-> sda_m_oe)
		else $error("start not made by master");
	AST_STOP_AFTER_ACK: assert property (stop |-> cnt == 4'h1)
		else $error("stop inside a byte");
	AST_STOP_RELEASED: assert property (stop |=> !sda_s_oe [*8])
		else $error("slave drives after stop");
	AST_ACK_HELD: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*8])
		else $error("slave low not held over clock high");
	AST_NACK_RELEASE: assert property ($rose(scl) && cnt == 4'h8 && sda |=> !sda_s_oe [*8])
		else $error("slave drives after no ack");
	// Main scenarios seen
	cover property (start);
	cover property ($rose(scl) && cnt == 4'h8 && sda_s_oe);
	cover property ($rose(scl) && cnt == 4'h8 && sda);
endmodule : rtcc_assertions
`default_nettype wire

// *** rtcc_two_wire_slave_front_end_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtcc_two_wire_slave_front_end_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic on_backup = 1'b0;
	logic mfp_level = 1'b0;
	logic rx_ready = 1'b1;
	logic [7:0] tx_data = 8'h00;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_flags = 4'h0;
	logic [7:0] cmd_data = 8'h00;
	logic [7:0] a;
	logic [7:0] d0;
	logic [1:0] e;
	logic [7:0] bad [5] = '{8'hce, 8'hdc, 8'hda, 8'h5e, 8'hdf};
	wire logic mfp_oe, rx_valid, rx_first, tx_take, busy, read_not_write_bit, cmd_ready, done, ack;
	wire logic [7:0] rx_data;
	wire logic [7:0] rd_data;
	int fail_count = 0;
	int samples_checked = 0;
	logic [1:0] exp_q [$];
	logic [7:0] tx_q [$];
	logic [8:0] rx_q [$];
	// Free running clock, 20 ns
	always #10 clk = ~clk;
	rtcc_bus_if bus ();
	rtcc_slave u_rtcc_slave (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .BUS(bus),
		.ON_BACKUP_IN(on_backup), .MFP_LEVEL_IN(mfp_level),
		.MULTIFUNCTION_OUTPUT_PIN_OE_OUT(mfp_oe), .RX_VALID_OUT(rx_valid),
		.RX_READY_IN(rx_ready), .RX_DATA_OUT(rx_data), .RX_FIRST_OUT(rx_first),
		.TX_DATA_IN(tx_data), .TX_TAKE_OUT(tx_take), .BUSY_OUT(busy),
		.READ_NOT_WRITE_BIT_OUT(read_not_write_bit));
	rtcc_master u_rtcc_master (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .BUS(bus),
		.CMD_VALID_IN(cmd_valid), .CMD_START_IN(cmd_flags[3]), .CMD_STOP_IN(cmd_flags[2]),
		.CMD_READ_IN(cmd_flags[1]), .CMD_LAST_IN(cmd_flags[0]), .CMD_DATA_IN(cmd_data),
		.CMD_READY_OUT(cmd_ready), .DONE_OUT(done), .ACK_OUT(ack), .RD_DATA_OUT(rd_data));
	rtcc_assertions u_rtcc_assertions (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
		.scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe),
		.scl(bus.scl), .sda(bus.sda));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// One byte command; flags are start, stop, read, last
	task automatic cmd(input logic [3:0] f, input logic [7:0] d, input logic ea);
		@(posedge clk);
		while (cmd_ready !== 1'b1) @(posedge clk);
		exp_q.push_back({f[1], ea});
		cmd_valid <= 1'b1;
		cmd_flags <= f;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		while (done !== 1'b1) @(posedge clk);
	endtask : cmd
	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	// Read bytes are judged on data, written bytes on the ack answer
	always @(posedge clk) begin
		if (done === 1'b1) begin
			e = exp_q.pop_front();
			if (e[1]) check("read byte", {1'b0, rd_data}, {1'b0, tx_q.pop_front()});
			else check("ack", {8'h00, ack}, {8'h00, e[0]});
		end
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check("rx byte", {rx_first, rx_data}, rx_q.pop_front());
		if (tx_take === 1'b1) begin
			tx_q.push_back(tx_data);
			tx_data <= 8'($urandom);
		end
	end
	// Cuts a hang; normal run needs about a quarter of this
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(14));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// Stalled receiver: two bytes fit, the third is refused
		a = 8'($urandom_range(95));
		d0 = 8'($urandom);
		rx_q.push_back({1'b1, a});
		rx_q.push_back({1'b0, d0});
		rx_ready <= 1'b0;
		cmd(4'h8, 8'hde, 1'b1);
		check("direction", {8'h00, read_not_write_bit}, 9'h000);
		check("busy", {8'h00, busy}, 9'h001);
		cmd(4'h0, a, 1'b1);
		cmd(4'h0, d0, 1'b1);
		cmd(4'h4, 8'($urandom), 1'b0);
		rx_ready <= 1'b1;
		repeat (10) @(posedge clk);
		check("rx left", 9'(rx_q.size()), 9'h000);
		check("idle", {8'h00, busy}, 9'h000);
		$display("write test done");
		// Wrong control codes and chip selects, then backup power
		for (int i = 0; i < 4; i++) cmd(4'hc, bad[i], 1'b0);
		on_backup <= 1'b1;
		cmd(4'hc, 8'hde, 1'b0);
		on_backup <= 1'b0;
		$display("address test done");
		// Register address window top edge, 0x60 refused and 0x5F taken
		cmd(4'h8, 8'hde, 1'b1);
		cmd(4'h4, 8'h60, 1'b0);
		rx_q.push_back({1'b1, 8'h5f});
		cmd(4'h8, 8'hde, 1'b1);
		cmd(4'h4, 8'h5f, 1'b1);
		$display("range test done");
		// Read of three bytes, the last not acknowledged
		tx_q.delete();
		cmd(4'h8, bad[4], 1'b1);
		check("direction", {8'h00, read_not_write_bit}, 9'h001);
		cmd(4'h2, 8'h00, 1'b0);
		cmd(4'h2, 8'h00, 1'b0);
		cmd(4'h7, 8'h00, 1'b0);
		$display("read test done");
		// Pin pulled low exactly while the level is low
		for (int i = 0; i < 2; i++) begin
			mfp_level <= i[0];
			repeat (3) @(posedge clk);
			check("pin drive", {8'h00, mfp_oe}, {8'h00, ~i[0]});
		end
		$display("pin test done");
		give_verdict();
	end
endmodule : rtcc_two_wire_slave_front_end_tb
`default_nettype wire
